// ==== hw/mltba_top.sv ====
// Six-lane transmit aggregation with byte-clock alignment and receive error reporting
//
// Operation
// R1: Six serial links; lanes 0-3 on eight-lane macro, lanes 4-5 on four-lane macro.
// R2: Lanes are aligned by inserting special 8b10b comma symbols into every lane.
// R3: All transmit lanes act as one logical clock domain, byte strobes phase aligned.
// R4: Each lane has its own divider; sync role 1 is master, 0 is slave.
// R5: Slave aligns divider to lower neighbour; master alignment pulse travels up the chain.
// R6: Config logic holds four-lane macro lanes master until both PLLs lock.
// R7: Byte-clock source select 0 makes eight-lane macro the transmit byte-clock source.
// R8: Receive side reports line code violations, decode errors and lost symbol alignment.
// R9: Lock status of each macro PLL is shown to the configuration logic.
`timescale 1ns/1ps
`include "mltba_defs.svh"

module mltba_top (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic [`MLTBA_LANES-1:0] lane_sync_role,
  input  wire logic                    byte_clock_source_select,
  input  wire logic                    eight_lane_macro_pll_lock,
  input  wire logic                    four_lane_macro_pll_lock,
  input  wire logic                    in_valid,
  output logic                         in_ready,
  input  wire mltba_pkg::mltba_col_t   in_col,
  output mltba_pkg::mltba_col_t        tx_col,
  output logic                         tx_strobe,
  output logic [`MLTBA_LANES-1:0]      lane_byte_strobe,
  input  wire logic                    rx_valid,
  input  wire mltba_pkg::mltba_rx_col_t rx_col,
  output logic [`MLTBA_LANES-1:0]      line_code_violation,
  output logic [`MLTBA_LANES-1:0]      rx_decode_error,
  output logic                         rx_align_loss,
  output logic [1:0]                   pll_lock_status,
  output logic                         pll_all_locked
);
  import mltba_pkg::*;

  // Lane dividers
  logic [`MLTBA_LANES-1:0] align_chain;
  logic [`MLTBA_LANES-1:0] align_in_vec;

  // Lane 0 has no lower neighbour, so it never receives a pulse
  assign align_in_vec = {align_chain[`MLTBA_LANES-2:0], 1'b0}; // R5

  // One divider per link; lanes 0-3 belong to the eight-lane macro, 4-5 to the four-lane one
  // All leave reset in step, so snapping only matters after a phase slip
  genvar gi;
  generate
    for (gi = 0; gi < `MLTBA_LANES; gi = gi + 1) begin : g_lane // R1
      mltba_lane_div u_div (
        .clk         (clk),
        .srst        (srst),
        .sync_role   (lane_sync_role[gi]),
        .align_in    (align_in_vec[gi]),
        .align_out   (align_chain[gi]),
        .byte_strobe (lane_byte_strobe[gi])
      ); // R4
    end
  endgenerate

  // Byte-clock source selection
  logic src_eight;
  logic src_strobe;

  // The four-lane macro's first lane stands in for that macro's byte clock
  assign src_eight  = (byte_clock_source_select == `MLTBA_SRC_EIGHT); // R7
  assign src_strobe = src_eight ? lane_byte_strobe[0] : lane_byte_strobe[`MLTBA_FOUR_FIRST]; // R7

  // Every lane is loaded on the same strobe: one logical domain for all lanes
  // Lanes share one phase, so a source change mid-run leaves no runt slot
  assign tx_strobe = src_strobe; // R3

  // Two-entry input buffer
  mltba_col_t buf_mem [0:1];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] buf_cnt;
  logic [1:0] next_buf_cnt;
  logic       buf_full;
  logic       buf_empty;
  logic       buf_push;
  logic       buf_pop;

  // Full and empty straight from the occupancy count
  assign buf_full     = (buf_cnt == 2'h2);
  assign buf_empty    = (buf_cnt == 2'h0);
  assign in_ready     = !buf_full;
  assign buf_push     = in_valid && !buf_full;
  assign next_buf_cnt = buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};

  // Buffer pointers and count
  // Push and pop may meet in one edge; the count nets them out
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      wr_ptr  <= wr_ptr ^ buf_push;
      rd_ptr  <= rd_ptr ^ buf_pop;
      buf_cnt <= next_buf_cnt;
    end
  end

  // Storage needs no reset; occupancy guards every read
  always_ff @(posedge clk) begin
    if (buf_push) begin
      buf_mem[wr_ptr] <= in_col;
    end
  end

  // Transmit slot selection
  logic [3:0] align_cnt;
  logic [3:0] next_align_cnt;
  logic       slot_comma;
  logic       align_wrap;
  mltba_col_t buf_head;
  mltba_sel_t sel;
  mltba_col_t next_tx_col;

  // Period decode and the oldest buffered column
  assign slot_comma = (align_cnt == `MLTBA_ALIGN_RESET); // R2
  assign align_wrap = (align_cnt == `MLTBA_ALIGN_LAST);
  assign buf_head   = buf_mem[rd_ptr];

  // Comma column first in each period, then data, idle when starved
  assign sel = slot_comma   ? MLTBA_SEL_ALIGN :
               (!buf_empty) ? MLTBA_SEL_DATA  : MLTBA_SEL_IDLE; // R2

  // Only a data slot drains the buffer, so the sender stalls while commas go out
  assign buf_pop = src_strobe && (sel == MLTBA_SEL_DATA);

  // Slot count within the comma period, wraps after the last slot
  assign next_align_cnt = align_wrap ? `MLTBA_ALIGN_RESET : align_cnt + 4'h1;

  // Column builder: same symbol kind in the same slot on every lane
  always_comb begin
    next_tx_col = tx_col;
    unique case (sel)
      MLTBA_SEL_ALIGN: begin
        for (int i = 0; i < `MLTBA_LANES; i++) begin
          next_tx_col[i] = '{k: 1'b1, data: `MLTBA_COMMA}; // R2
        end
      end
      MLTBA_SEL_DATA: begin
        next_tx_col = buf_head;
      end
      MLTBA_SEL_IDLE: begin
        for (int i = 0; i < `MLTBA_LANES; i++) begin
          next_tx_col[i] = '{k: 1'b1, data: `MLTBA_IDLE};
        end
      end
      default: begin
        next_tx_col = tx_col;
      end
    endcase
  end

  // Output column and period counter advance only on the source strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      align_cnt <= `MLTBA_ALIGN_RESET;
      tx_col    <= '0;
    end else if (src_strobe) begin
      align_cnt <= next_align_cnt;
      tx_col    <= next_tx_col; // R3
    end
  end

  // Receive error reporting
  logic [`MLTBA_LANES-1:0] rx_comma;
  logic [`MLTBA_LANES-1:0] rx_viol_hit;
  logic [`MLTBA_LANES-1:0] rx_dec_hit;
  logic                    rx_any_comma;
  logic                    rx_all_comma;
  logic                    rx_skew;

  // Per-lane decode of the receive column
  generate
    for (gi = 0; gi < `MLTBA_LANES; gi = gi + 1) begin : g_rx
      assign rx_comma[gi]    = rx_col[gi].k && (rx_col[gi].data == `MLTBA_COMMA);
      assign rx_viol_hit[gi] = rx_valid && rx_col[gi].code_viol; // R8
      assign rx_dec_hit[gi]  = rx_valid && rx_col[gi].dec_err; // R8
    end
  endgenerate

  // Commas on some lanes but not all means the lanes have slipped apart
  assign rx_any_comma = (rx_comma != '0);
  assign rx_all_comma = (rx_comma == '1);
  assign rx_skew      = rx_valid && rx_any_comma && !rx_all_comma; // R8

  // One-cycle report pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      line_code_violation <= '0;
      rx_decode_error     <= '0;
      rx_align_loss       <= 1'b0;
    end else begin
      line_code_violation <= rx_viol_hit;
      rx_decode_error     <= rx_dec_hit;
      rx_align_loss       <= rx_skew;
    end
  end

  // PLL lock status
  logic pll_both;

  // Both macros locked: the point where the four-lane lanes may drop back to slave
  assign pll_both = eight_lane_macro_pll_lock && four_lane_macro_pll_lock;

  // Registered so the role sequencer outside sees a clean level
  always_ff @(posedge clk) begin
    if (srst) begin
      pll_lock_status <= 2'h0;
      pll_all_locked  <= 1'b0;
    end else begin
      pll_lock_status <= {four_lane_macro_pll_lock, eight_lane_macro_pll_lock}; // R9
      pll_all_locked  <= pll_both; // R9
    end
  end

endmodule

// ==== hw/mltba_defs.svh ====
// Constants for the multi-lane transmit byte-clock alignment block
`ifndef MLTBA_DEFS_SVH
`define MLTBA_DEFS_SVH

// Lane counts per SerDes macro
`define MLTBA_LANES         6
`define MLTBA_EIGHT_LANES   4
`define MLTBA_FOUR_LANES    2
`define MLTBA_FOUR_FIRST    3'h4

// Byte-clock divider: one byte strobe every DIV_RATIO clocks
`define MLTBA_DIV_RATIO     4
`define MLTBA_DIV_LAST      2'h3
`define MLTBA_DIV_RESET     2'h0

// Alignment symbol insertion: one comma column every 16 byte slots (MLTBA_ALIGN_LAST plus one)
`define MLTBA_ALIGN_LAST    4'hf
`define MLTBA_ALIGN_RESET   4'h0

// Special 8b10b symbols (K28.5 comma, K28.3 idle filler)
`define MLTBA_COMMA         8'hbc
`define MLTBA_IDLE          8'h7c

// Byte-clock source select encodings
`define MLTBA_SRC_EIGHT     1'h0
`define MLTBA_SRC_FOUR      1'h1

// Sync role encodings
`define MLTBA_ROLE_MASTER   1'h1
`define MLTBA_ROLE_SLAVE    1'h0

`endif

// ==== hw/mltba_pkg.sv ====
// Types shared by the lane alignment block
`include "mltba_defs.svh"

package mltba_pkg;

  // One 8b10b symbol before encoding: control flag plus byte
  typedef struct packed {
    logic       k;
    logic [7:0] data;
  } mltba_sym_t;

  // One column of symbols, one per transmit lane
  typedef mltba_sym_t [`MLTBA_LANES-1:0] mltba_col_t;

  // Per-lane report from the receive decoder
  typedef struct packed {
    logic       k;
    logic [7:0] data;
    logic       code_viol;
    logic       dec_err;
  } mltba_rx_t;

  typedef mltba_rx_t [`MLTBA_LANES-1:0] mltba_rx_col_t;

  // What the transmit stage puts on the lanes in a byte slot
  typedef enum logic [1:0] {
    MLTBA_SEL_ALIGN = 2'h0,
    MLTBA_SEL_DATA  = 2'h1,
    MLTBA_SEL_IDLE  = 2'h2
  } mltba_sel_t;

endpackage

// ==== hw/mltba_lane_div.sv ====
// Per-lane transmit byte-clock divider with master/slave phase alignment
`timescale 1ns/1ps
`include "mltba_defs.svh"

module mltba_lane_div (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic sync_role,
  input  wire logic align_in,
  output logic      align_out,
  output logic      byte_strobe
);
  import mltba_pkg::*;

  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic       wrap;
  logic       is_master;

  // Divider phase decode
  assign is_master   = (sync_role == `MLTBA_ROLE_MASTER); // R4
  assign wrap        = (cnt == `MLTBA_DIV_LAST);
  assign byte_strobe = wrap;

  // Master launches the pulse; a slave passes its neighbour's pulse on
  assign align_out = is_master ? wrap : align_in; // R5

  // Slave snaps to the neighbour's wrap so both restart at zero together
  assign next_cnt = (wrap || (!is_master && align_in)) ? `MLTBA_DIV_RESET : cnt + 2'h1; // R5

  // Divider counter
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= `MLTBA_DIV_RESET;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// ==== tb/mltba_top_properties.sv ====
// Port checker for the lane alignment block
`timescale 1ns/1ps
`include "mltba_defs.svh"
module mltba_top_chk (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire logic                     byte_clock_source_select,
  input wire logic                     eight_lane_macro_pll_lock,
  input wire logic                     four_lane_macro_pll_lock,
  input wire mltba_pkg::mltba_col_t    tx_col,
  input wire logic                     tx_strobe,
  input wire logic [`MLTBA_LANES-1:0]  lane_byte_strobe,
  input wire logic                     rx_valid,
  input wire mltba_pkg::mltba_rx_col_t rx_col,
  input wire logic [`MLTBA_LANES-1:0]  line_code_violation,
  input wire logic [`MLTBA_LANES-1:0]  rx_decode_error,
  input wire logic                     rx_align_loss,
  input wire logic [1:0]               pll_lock_status,
  input wire logic                     pll_all_locked
);
  import mltba_pkg::*;
  localparam mltba_col_t comma_col = {`MLTBA_LANES{1'b1, `MLTBA_COMMA}};
  logic [5:0] viol_exp, derr_exp, cm;
  logic       lost;
  // Expected receive reports, zero when no column arrives
  always_comb begin
    for (int i = 0; i < `MLTBA_LANES; i++) begin
      viol_exp[i] = rx_valid && rx_col[i].code_viol;
      derr_exp[i] = rx_valid && rx_col[i].dec_err;
      cm[i] = rx_col[i].k && (rx_col[i].data == `MLTBA_COMMA);
    end
    lost = rx_valid && (|cm) && !(&cm);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_strobe_period: assert property (
    |lane_byte_strobe |=> (lane_byte_strobe == 6'h0) [*3] ##1 (&lane_byte_strobe))
    else $error("byte strobe period wrong");
  chk_lanes_together: assert property (lane_byte_strobe == 6'h0 || (&lane_byte_strobe))
    else $error("lane byte strobes not aligned");
  chk_source_sel: assert property (
    tx_strobe == (byte_clock_source_select ? lane_byte_strobe[4] : lane_byte_strobe[0]))
    else $error("wrong byte clock source");
  chk_col_stands: assert property (!tx_strobe |=> $stable(tx_col))
    else $error("column changed between strobes");
  chk_comma_period: assert property (
    tx_strobe ##1 tx_col == comma_col |-> ##63 tx_strobe ##1 tx_col == comma_col)
    else $error("comma column not every sixteen slots");
  chk_viol_report: assert property (1'b1 |=> line_code_violation == $past(viol_exp))
    else $error("code violation report wrong");
  chk_decode_report: assert property (1'b1 |=> rx_decode_error == $past(derr_exp))
    else $error("decode error report wrong");
  chk_align_loss: assert property (1'b1 |=> rx_align_loss == $past(lost))
    else $error("alignment loss report wrong");
  chk_pll_copy: assert property (
    1'b1 |=> pll_lock_status == {$past(four_lane_macro_pll_lock), $past(eight_lane_macro_pll_lock)}
             && pll_all_locked == (&pll_lock_status))
    else $error("pll lock status wrong");
endmodule
bind mltba_top mltba_top_chk i_chk (
  .clk                       (clk),
  .srst                      (srst),
  .byte_clock_source_select  (byte_clock_source_select),
  .eight_lane_macro_pll_lock (eight_lane_macro_pll_lock),
  .four_lane_macro_pll_lock  (four_lane_macro_pll_lock),
  .tx_col                    (tx_col),
  .tx_strobe                 (tx_strobe),
  .lane_byte_strobe          (lane_byte_strobe),
  .rx_valid                  (rx_valid),
  .rx_col                    (rx_col),
  .line_code_violation       (line_code_violation),
  .rx_decode_error           (rx_decode_error),
  .rx_align_loss             (rx_align_loss),
  .pll_lock_status           (pll_lock_status),
  .pll_all_locked            (pll_all_locked)
);

// ==== tb/mltba_peer_rx.sv ====
// Chained peer receiver: returns each sent column with commanded faults
`timescale 1ns/1ps
`include "mltba_defs.svh"
module mltba_peer_rx (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    tx_strobe,
  input  wire mltba_pkg::mltba_col_t   tx_col,
  input  wire logic [`MLTBA_LANES-1:0] err_mask,
  input  wire logic                    skew,
  output logic                         rx_valid,
  output mltba_pkg::mltba_rx_col_t     rx_col
);
  import mltba_pkg::*;
  logic strobe_d;
  // Column is taken one edge after its strobe; off-slot the lines keep moving
  always @(posedge clk) begin
    strobe_d <= tx_strobe && !srst;
    rx_valid <= strobe_d && !srst;
    if (srst) begin
      rx_col <= '0;
    end else if (strobe_d) begin
      for (int i = 0; i < `MLTBA_LANES; i++) begin
        rx_col[i] <= {tx_col[i], err_mask[i], err_mask[(i+1)%`MLTBA_LANES]};
      end
      if (skew) rx_col[5] <= {1'b1, `MLTBA_IDLE, 2'b01};
    end else begin
      rx_col <= ~rx_col;
    end
  end
endmodule

// ==== tb/mltba_top_tb.sv ====
// Self-checking bench for the lane alignment block
`timescale 1ns/1ps
`include "mltba_defs.svh"
module mltba_top_tb;
  import mltba_pkg::*;
  typedef struct packed {logic [5:0] viol; logic [5:0] derr; logic lost;} mltba_rep_t;
  localparam mltba_col_t comma_col = {`MLTBA_LANES{1'b1, `MLTBA_COMMA}};
  localparam mltba_col_t idle_col  = {`MLTBA_LANES{1'b1, `MLTBA_IDLE}};
  logic          clk, srst, byte_clock_source_select, eight_lane_macro_pll_lock, four_lane_macro_pll_lock;
  logic          in_valid, in_ready, tx_strobe, rx_valid, skew, rx_align_loss, pll_all_locked;
  logic [5:0]    lane_sync_role, lane_byte_strobe, err_mask, line_code_violation, rx_decode_error;
  logic [1:0]    pll_lock_status;
  logic          traffic, taken, tx_seen, rx_seen;
  logic [31:0]   seed = 32'hdc7d;
  mltba_col_t    in_col, tx_col;
  mltba_rx_col_t rx_col;
  mltba_col_t    exp_tx[$];
  mltba_rep_t    exp_rx[$];
  int            errors, n_compared;
  mltba_top i_dut (
    .clk                       (clk),
    .srst                      (srst),
    .lane_sync_role            (lane_sync_role),
    .byte_clock_source_select  (byte_clock_source_select),
    .eight_lane_macro_pll_lock (eight_lane_macro_pll_lock),
    .four_lane_macro_pll_lock  (four_lane_macro_pll_lock),
    .in_valid                  (in_valid),
    .in_ready                  (in_ready),
    .in_col                    (in_col),
    .tx_col                    (tx_col),
    .tx_strobe                 (tx_strobe),
    .lane_byte_strobe          (lane_byte_strobe),
    .rx_valid                  (rx_valid),
    .rx_col                    (rx_col),
    .line_code_violation       (line_code_violation),
    .rx_decode_error           (rx_decode_error),
    .rx_align_loss             (rx_align_loss),
    .pll_lock_status           (pll_lock_status),
    .pll_all_locked            (pll_all_locked)
  );
  mltba_peer_rx i_peer (
    .clk       (clk),
    .srst      (srst),
    .tx_strobe (tx_strobe),
    .tx_col    (tx_col),
    .err_mask  (err_mask),
    .skew      (skew),
    .rx_valid  (rx_valid),
    .rx_col    (rx_col)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic mltba_rep_t expect_rep(input mltba_rx_col_t c);
    mltba_rep_t r;
    logic [5:0] cm;
    for (int i = 0; i < `MLTBA_LANES; i++) begin
      r.viol[i] = c[i].code_viol;
      r.derr[i] = c[i].dec_err;
      cm[i] = c[i].k && c[i].data == `MLTBA_COMMA;
    end
    r.lost = (|cm) && !(&cm);
    return r;
  endfunction
  task automatic cmp_tx(input mltba_col_t got, input mltba_col_t exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: tx column %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rx(input mltba_rep_t got, input mltba_rep_t exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: rx report %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Run needs some 2600 cycles; far beyond that means a hang
  initial begin
    #(25 * 20000);
    errors++;
    results();
  end
  // Random columns twice as fast as the slots drain, so the buffer fills
  always @(negedge clk) begin
    seed = lfsr(seed);
    if (!in_valid || taken) begin
      in_valid = traffic && seed[3];
      for (int i = 0; i < `MLTBA_LANES; i++) in_col[i] = {1'b0, seed[i*4 +: 8]};
    end
    err_mask = (seed[31:29] == 3'h0) ? seed[9:4] : 6'h0;
  end
  // Note accepted columns and arriving receive columns
  always @(posedge clk) begin
    taken <= in_valid && in_ready && !srst;
    tx_seen <= tx_strobe && !srst;
    rx_seen <= rx_valid && !srst;
    if (in_valid && in_ready && !srst) exp_tx.push_back(in_col);
    if (rx_valid && !srst) exp_rx.push_back(expect_rep(rx_col));
  end
  // Data columns leave in order; fill slots carry idle or comma
  always @(negedge clk) begin
    if (tx_seen && tx_col[0].k === 1'b0) cmp_tx(tx_col, exp_tx.size() ? exp_tx.pop_front() : ~tx_col);
    else if (tx_seen && tx_col !== comma_col) cmp_tx(tx_col, idle_col);
    if (rx_seen) cmp_rx({line_code_violation, rx_decode_error, rx_align_loss}, exp_rx.pop_front());
  end
  initial begin
    srst = 1'b1;
    traffic = 1'b0;
    in_valid = 1'b0;
    in_col = '0;
    err_mask = '0;
    skew = 1'b0;
    lane_sync_role = 6'h31;
    byte_clock_source_select = `MLTBA_SRC_EIGHT;
    eight_lane_macro_pll_lock = 1'b0;
    four_lane_macro_pll_lock = 1'b0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (20) @(negedge clk);
    eight_lane_macro_pll_lock = 1'b1;
    repeat (20) @(negedge clk);
    four_lane_macro_pll_lock = 1'b1;
    for (int i = 0; i < 10 && pll_all_locked !== 1'b1; i++) @(negedge clk);
    if (pll_all_locked !== 1'b1) begin
      errors++;
      $display("ERROR %0t: lock wait ran out", $time);
    end
    lane_sync_role = 6'h01;
    traffic = 1'b1;
    repeat (1000) @(negedge clk);
    skew = 1'b1;
    repeat (300) @(negedge clk);
    skew = 1'b0;
    byte_clock_source_select = `MLTBA_SRC_FOUR;
    repeat (1000) @(negedge clk);
    traffic = 1'b0;
    repeat (200) @(negedge clk);
    cmp_tx(mltba_col_t'(exp_tx.size()), '0);
    cmp_rx(mltba_rep_t'(exp_rx.size()), '0);
    results();
  end
endmodule
